// File: tmo_defines.vh
// Purpose: Register map, field positions and reset values of the timer one block.
// Assumes: APB with 32-bit data, one register to an aligned word.
// Notes: Definitions only.
`ifndef TMO_DEFINES_VH
`define TMO_DEFINES_VH
`define TMO_ADDR_CTRL     8'h00
`define TMO_ADDR_CNT_LO   8'h04
`define TMO_ADDR_CNT_HI   8'h08
`define TMO_ADDR_IRQ_STAT 8'h0c
`define TMO_ADDR_IRQ_MASK 8'h10
`define TMO_ADDR_EVT_CFG  8'h14
`define TMO_BIT_RUN       0
`define TMO_BIT_CLKSEL    1
`define TMO_BIT_SYNCBYP   2
`define TMO_BIT_OSCEN     3
`define TMO_BIT_PS_LO     4
`define TMO_BIT_PS_HI     5
`define TMO_BIT_SYSCLK    6
`define TMO_BIT_WIDE      7
`define TMO_CTRL_RESET    8'h00
`define TMO_CTRL_WMASK    8'hbf
`define TMO_CNT_RESET     16'h0000
`define TMO_CNT_MAX       16'hffff
`define TMO_IFD_DIV       2'h3
`define TMO_PS_ONE        2'h0
`define TMO_PS_TWO        2'h1
`define TMO_PS_FOUR       2'h2
`define TMO_PS_EIGHT      2'h3
`endif

// File: tmo_timer.v
// Purpose: Sixteen-bit timer/counter with 8-bit control register, prescaler and APB register access.
// Assumes: All inputs synchronous to REF_CLK; the external clock pin is sampled by REF_CLK.
// Notes: Registers at 0x00 control, 0x04 low byte, 0x08 high byte, 0x0c status, 0x10 mask, 0x14 event enable.
`timescale 1ns/1ps
`include "tmo_defines.vh"
module tmo_timer #(
	parameter PS_W = 3
) (
	input  wire        REF_CLK,
	input  wire        RST,
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	input  wire [3:0]  PSTRB,
	output reg  [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	input  wire        EXTERNAL_CLOCK_PIN,
	input  wire        SPECIAL_EVENT_TRIGGER,
	input  wire        SYSCLK_FROM_AUX_OSC,
	output reg         AUX_OSC_ENABLE,
	output reg         IRQ
);
	reg  [7:0]      ctrl_ff;
	reg  [7:0]      nxt_ctrl;
	reg  [7:0]      cnt_lo_ff;
	reg  [7:0]      nxt_cnt_lo;
	reg  [7:0]      cnt_hi_ff;
	reg  [7:0]      nxt_cnt_hi;
	reg  [7:0]      hi_buf_ff;
	reg  [7:0]      nxt_hi_buf;
	reg  [PS_W-1:0] ps_cnt_ff;
	reg  [PS_W-1:0] nxt_ps_cnt;
	reg  [1:0]      ifd_ff;
	reg             sync1_ff;
	reg             sync2_ff;
	reg             prev_ext_ff;
	reg             sysclk_ff;
	reg  [0:0]      irq_stat_ff;
	reg  [0:0]      irq_mask_ff;
	reg             evt_en_ff;
	reg             ready_ff;
	reg  [31:0]     nxt_rdata;
	reg             tick;
	reg             ps_out;
	reg             ovf;
	reg  [15:0]     cnt_inc;
	wire            access;
	wire            wr;
	wire            rd;
	wire            wr_lane0;
	wire            ext_level;
	wire            ext_rise;
	wire            int_tick;
	wire            wide;
	reg             nxt_irq_stat;
	reg             nxt_irq_mask;
	reg             nxt_evt_en;
	reg  [31:0]     nxt_prdata;
	wire            stat_clr;
	wire            mask_wr;
	wire            evt_wr;
	wire            rd_setup;

	// Prescale mask for a ratio code, zero for divide by one: the prescaler output fires when masked bits are all ones.
	function [PS_W-1:0] ps_mask;
		input [1:0] sel;
		begin
			case (sel)
				`TMO_PS_ONE:   ps_mask = {PS_W{1'b0}};
				`TMO_PS_TWO:   ps_mask = {PS_W{1'b1}} >> (PS_W - 1);
				`TMO_PS_FOUR:  ps_mask = {PS_W{1'b1}} >> (PS_W - 2);
				`TMO_PS_EIGHT: ps_mask = {PS_W{1'b1}} >> (PS_W - 3);
				default:       ps_mask = {PS_W{1'b0}};
			endcase
		end
	endfunction

	// One-cycle transfer: setup then a single access cycle with PREADY high.
	assign access   = PSEL & PENABLE & ready_ff;
	assign wr       = access & PWRITE;
	assign rd       = access & ~PWRITE;
	assign wr_lane0 = wr & PSTRB[0];
	assign PREADY   = ready_ff;
	assign PSLVERR  = 1'b0;
	assign wide     = ctrl_ff[`TMO_BIT_WIDE];

	always @(posedge REF_CLK) begin
		if (RST) begin
			ready_ff <= 1'b0;
		end else begin
			ready_ff <= PSEL & ~PENABLE;
		end
	end

	// Instruction clock is the reference divided by four.
	always @(posedge REF_CLK) begin
		if (RST) begin
			ifd_ff <= 2'h0;
		end else begin
			ifd_ff <= ifd_ff + 2'h1;
		end
	end
	assign int_tick = (ifd_ff == `TMO_IFD_DIV);

	// Two-stage synchroniser for the external clock pin.
	always @(posedge REF_CLK) begin
		if (RST) begin
			sync1_ff <= 1'b0;
		end else begin
			sync1_ff <= EXTERNAL_CLOCK_PIN;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			sync2_ff <= 1'b0;
		end else begin
			sync2_ff <= sync1_ff;
		end
	end

	// Previous level of the selected path, for rising edge detection.
	always @(posedge REF_CLK) begin
		if (RST) begin
			prev_ext_ff <= 1'b0;
		end else begin
			prev_ext_ff <= ext_level;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			sysclk_ff <= 1'b0;
		end else begin
			sysclk_ff <= SYSCLK_FROM_AUX_OSC;
		end
	end
	// Bypass path takes the pin unregistered; synchronised path goes through two stages.
	assign ext_level = ctrl_ff[`TMO_BIT_SYNCBYP] ? EXTERNAL_CLOCK_PIN : sync2_ff;
	assign ext_rise  = ext_level & ~prev_ext_ff;

	always @* begin
		if (ctrl_ff[`TMO_BIT_CLKSEL]) begin
			tick = ext_rise;
		end else begin
			tick = int_tick;
		end
		ps_out  = tick & ((ps_cnt_ff & ps_mask(ctrl_ff[`TMO_BIT_PS_HI:`TMO_BIT_PS_LO])) ==
			ps_mask(ctrl_ff[`TMO_BIT_PS_HI:`TMO_BIT_PS_LO]));
		cnt_inc = {cnt_hi_ff, cnt_lo_ff} + 16'h0001;
		ovf     = 1'b0;
		nxt_ps_cnt = ps_cnt_ff;
		nxt_cnt_lo = cnt_lo_ff;
		nxt_cnt_hi = cnt_hi_ff;
		nxt_hi_buf = hi_buf_ff;
		nxt_ctrl   = ctrl_ff;
		if (ctrl_ff[`TMO_BIT_RUN] && tick) begin
			nxt_ps_cnt = ps_cnt_ff + {{(PS_W-1){1'b0}}, 1'b1};
			if (ps_out) begin
				{nxt_cnt_hi, nxt_cnt_lo} = cnt_inc;
				ovf = ({cnt_hi_ff, cnt_lo_ff} == `TMO_CNT_MAX);
			end
		end
		if (evt_en_ff && SPECIAL_EVENT_TRIGGER) begin
			nxt_cnt_lo = 8'h00;
			nxt_cnt_hi = 8'h00;
		end
		if (rd && PADDR == `TMO_ADDR_CNT_LO && wide) begin
			nxt_hi_buf = cnt_hi_ff;
		end
		if (wr_lane0) begin
			case (PADDR)
				`TMO_ADDR_CTRL: begin
					nxt_ctrl = PWDATA[7:0] & `TMO_CTRL_WMASK;
				end
				`TMO_ADDR_CNT_LO: begin
					nxt_cnt_lo = PWDATA[7:0];
					nxt_ps_cnt = {PS_W{1'b0}};
					if (wide) begin
						nxt_cnt_hi = hi_buf_ff;
					end
				end
				`TMO_ADDR_CNT_HI: begin
					if (wide) begin
						nxt_hi_buf = PWDATA[7:0];
					end else begin
						nxt_cnt_hi = PWDATA[7:0];
					end
				end
				default: begin
					nxt_ctrl = ctrl_ff;
				end
			endcase
		end
	end

	always @* begin
		nxt_rdata = 32'h0000_0000;
		case (PADDR)
			`TMO_ADDR_CTRL:     nxt_rdata[7:0] = {ctrl_ff[7], sysclk_ff, ctrl_ff[5:0]};
			`TMO_ADDR_CNT_LO:   nxt_rdata[7:0] = cnt_lo_ff;
			`TMO_ADDR_CNT_HI:   nxt_rdata[7:0] = wide ? hi_buf_ff : cnt_hi_ff;
			`TMO_ADDR_IRQ_STAT: nxt_rdata[0]   = irq_stat_ff[0];
			`TMO_ADDR_IRQ_MASK: nxt_rdata[0]   = irq_mask_ff[0];
			`TMO_ADDR_EVT_CFG:  nxt_rdata[0]   = evt_en_ff;
			default:            nxt_rdata      = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the setup cycle so that it stands through the access cycle.
	assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
	assign stat_clr = wr_lane0 & (PADDR == `TMO_ADDR_IRQ_STAT) & PWDATA[0];
	assign mask_wr  = wr_lane0 & (PADDR == `TMO_ADDR_IRQ_MASK);
	assign evt_wr   = wr_lane0 & (PADDR == `TMO_ADDR_EVT_CFG);

	// Next interrupt state; an overflow in the clearing cycle keeps the flag set.
	always @* begin
		nxt_irq_stat = irq_stat_ff[0];
		nxt_irq_mask = irq_mask_ff[0];
		nxt_evt_en   = evt_en_ff;
		nxt_prdata   = PRDATA;
		if (ovf) begin
			nxt_irq_stat = 1'b1;
		end else if (stat_clr) begin
			nxt_irq_stat = 1'b0;
		end
		if (mask_wr) begin
			nxt_irq_mask = PWDATA[0];
		end
		if (evt_wr) begin
			nxt_evt_en = PWDATA[0];
		end
		if (rd_setup) begin
			nxt_prdata = nxt_rdata;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			ctrl_ff <= `TMO_CTRL_RESET;
		end else begin
			ctrl_ff <= nxt_ctrl;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			cnt_lo_ff <= 8'h00;
		end else begin
			cnt_lo_ff <= nxt_cnt_lo;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			cnt_hi_ff <= 8'h00;
		end else begin
			cnt_hi_ff <= nxt_cnt_hi;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			hi_buf_ff <= 8'h00;
		end else begin
			hi_buf_ff <= nxt_hi_buf;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			ps_cnt_ff <= {PS_W{1'b0}};
		end else begin
			ps_cnt_ff <= nxt_ps_cnt;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			irq_stat_ff <= 1'b0;
		end else begin
			irq_stat_ff <= nxt_irq_stat;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			irq_mask_ff <= 1'b0;
		end else begin
			irq_mask_ff <= nxt_irq_mask;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			evt_en_ff <= 1'b0;
		end else begin
			evt_en_ff <= nxt_evt_en;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			PRDATA <= 32'h0000_0000;
		end else begin
			PRDATA <= nxt_prdata;
		end
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			AUX_OSC_ENABLE <= 1'b0;
		end else begin
			AUX_OSC_ENABLE <= nxt_ctrl[`TMO_BIT_OSCEN];
		end
	end

	// The interrupt follows the next status and mask, so it drops on the same edge as a clear.
	always @(posedge REF_CLK) begin
		if (RST) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= nxt_irq_stat & nxt_irq_mask;
		end
	end
endmodule // tmo_timer

// File: tmo_timer_properties.sv
// Purpose: Port assertions for tmo_timer.
// Assumes: One clock REF_CLK, synchronous RST.
// Notes: Bound to every tmo_timer.
`timescale 1ns/1ps
module tmo_timer_properties (
	input wire        REF_CLK,
	input wire        RST,
	input wire        PSEL,
	input wire        PENABLE,
	input wire        PWRITE,
	input wire [7:0]  PADDR,
	input wire [31:0] PWDATA,
	input wire [3:0]  PSTRB,
	input wire [31:0] PRDATA,
	input wire        PREADY,
	input wire        PSLVERR,
	input wire        SYSCLK_FROM_AUX_OSC,
	input wire        AUX_OSC_ENABLE,
	input wire        IRQ
);
	wire rd = PSEL & PENABLE & PREADY & !PWRITE;
	wire wr = PSEL & PENABLE & PREADY & PWRITE & PSTRB[0];
	wire wc = wr & (PADDR == 8'h00);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	a_ready_due: assert property (PSEL & !PENABLE |=> PREADY) else $error("no ready");
	a_ready_once: assert property (PREADY |=> !PREADY) else $error("long ready");
	a_no_error: assert property (!PSLVERR) else $error("error response");
	a_unmapped_zero: assert property (rd && PADDR > 8'h14 |-> PRDATA == 32'h0) else $error("unmapped");
	a_status_view: assert property (rd && PADDR == 8'h00 |-> PRDATA[6] == $past(SYSCLK_FROM_AUX_OSC, 2))
		else $error("status bit");
	a_osc_write: assert property (wc |=> AUX_OSC_ENABLE == $past(PWDATA[3])) else $error("osc enable");
	a_osc_hold: assert property (!wc |=> $stable(AUX_OSC_ENABLE)) else $error("osc moved");
	a_irq_sticky: assert property (IRQ && !(wr && (PADDR == 8'h0c || PADDR == 8'h10)) |=> IRQ)
		else $error("irq dropped");
endmodule // tmo_timer_properties
bind tmo_timer tmo_timer_properties u_tmo_timer_properties (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .SYSCLK_FROM_AUX_OSC(SYSCLK_FROM_AUX_OSC),
	.AUX_OSC_ENABLE(AUX_OSC_ENABLE), .IRQ(IRQ));

// File: tmo_timer_test.sv
// Purpose: Self-checking bench for tmo_timer.
// Assumes: APB master on REF_CLK at 100 MHz.
// Notes: Seed 25 draws the byte values.
`timescale 1ns/1ps
module tmo_timer_test;
	reg         REF_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	reg         pin = 1'b0, trig = 1'b0, sysclk = 1'b0;
	reg  [7:0]  PADDR = 8'h00, a, b;
	reg  [31:0] PWDATA = 32'h0, rdata;
	wire [31:0] PRDATA;
	wire        PREADY, PSLVERR, osc_en, IRQ;
	integer     n_errors = 0, compares = 0, i, k, n;
	tmo_timer u_tmo_timer (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
		.PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hf), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.EXTERNAL_CLOCK_PIN(pin), .SPECIAL_EVENT_TRIGGER(trig), .SYSCLK_FROM_AUX_OSC(sysclk),
		.AUX_OSC_ENABLE(osc_en), .IRQ(IRQ));
	task end_of_test;
		begin
			$display("compares %0d n_errors %0d", compares, n_errors);
			if (n_errors == 0 && compares > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task hang;
		begin
			$display("unexpected %0t timeout", $time);
			n_errors = n_errors + 1;
			end_of_test;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			compares = compares + 1;
			if (got !== exp) begin
				$display("unexpected %0t got %h expected %h", $time, got, exp);
				n_errors = n_errors + 1;
			end
		end
	endtask
	task apb(input w, input [7:0] ad, input [7:0] d);
		integer t;
		begin
			@(posedge REF_CLK);
			PSEL <= 1'b1;
			PWRITE <= w;
			PADDR <= ad;
			PWDATA <= {24'h0, d};
			@(posedge REF_CLK);
			PENABLE <= 1'b1;
			t = 0;
			@(negedge REF_CLK);
			while (PREADY !== 1'b1 && t < 20) begin
				@(negedge REF_CLK);
				t = t + 1;
			end
			if (t == 20)
				hang;
			@(posedge REF_CLK);
			rdata = PRDATA;
			PSEL <= 1'b0;
			PENABLE <= 1'b0;
			@(posedge REF_CLK);
		end
	endtask
	task rd(input [7:0] ad, input [7:0] exp);
		begin
			apb(1'b0, ad, 8'h00);
			chk(rdata, {24'h0, exp});
		end
	endtask
	// A tick comes every fourth clock, so about 16 ticks fit the run window.
	function [31:0] in_span(input [31:0] cnt, input integer ps);
		in_span = (cnt >= (60 >> (ps + 2)) && cnt <= (72 >> (ps + 2)));
	endfunction
	initial begin
		forever #5 REF_CLK = ~REF_CLK;
	end
	initial begin
		n = $urandom(25);
		repeat (2) @(posedge REF_CLK);
		RST <= 1'b0;
		rd(8'h00, 8'h00);
		rd(8'h20, 8'h00);
		sysclk <= 1'b1;
		apb(1'b1, 8'h00, 8'hff);
		chk({31'h0, osc_en}, 32'h1);
		rd(8'h00, 8'hff);
		sysclk <= 1'b0;
		apb(1'b1, 8'h00, 8'h40);
		chk({31'h0, osc_en}, 32'h0);
		rd(8'h00, 8'h00);
		a = $urandom;
		b = $urandom;
		apb(1'b1, 8'h08, a);
		apb(1'b1, 8'h04, b);
		rd(8'h08, a);
		rd(8'h04, b);
		apb(1'b1, 8'h00, 8'h80);
		apb(1'b1, 8'h08, ~a);
		apb(1'b1, 8'h04, ~b);
		apb(1'b1, 8'h00, 8'h00);
		rd(8'h08, ~a);
		rd(8'h04, ~b);
		apb(1'b1, 8'h08, a);
		apb(1'b1, 8'h00, 8'h80);
		rd(8'h04, ~b);
		rd(8'h08, a);
		apb(1'b1, 8'h08, 8'hff);
		apb(1'b1, 8'h04, 8'hfe);
		apb(1'b1, 8'h10, 8'h01);
		apb(1'b1, 8'h00, 8'h01);
		for (k = 0; k < 100 && IRQ !== 1'b1; k = k + 1)
			@(posedge REF_CLK);
		if (k == 100)
			hang;
		apb(1'b1, 8'h00, 8'h00);
		rd(8'h0c, 8'h01);
		rd(8'h08, 8'h00);
		apb(1'b1, 8'h10, 8'h00);
		repeat (2) @(posedge REF_CLK);
		chk({31'h0, IRQ}, 32'h0);
		apb(1'b1, 8'h0c, 8'h01);
		rd(8'h0c, 8'h00);
		for (i = 0; i < 4; i = i + 1) begin
			apb(1'b1, 8'h04, 8'h00);
			apb(1'b1, 8'h00, {2'h0, i[1:0], 4'h5});
			repeat (64) @(posedge REF_CLK);
			apb(1'b1, 8'h00, 8'h00);
			apb(1'b0, 8'h04, 8'h00);
			chk(in_span(rdata, i), 32'h1);
		end
		apb(1'b1, 8'h14, 8'h01);
		for (i = 0; i < 2; i = i + 1) begin
			n = $urandom % 6 + 1;
			apb(1'b1, 8'h04, 8'h00);
			apb(1'b1, 8'h00, {5'h0, i[0], 2'h3});
			repeat (2 * n) begin
				repeat (4) @(posedge REF_CLK);
				pin <= ~pin;
			end
			repeat (4) @(posedge REF_CLK);
			rd(8'h04, n[7:0]);
			trig <= 1'b1;
			@(posedge REF_CLK);
			trig <= 1'b0;
			rd(8'h04, 8'h00);
		end
		end_of_test;
	end
endmodule // tmo_timer_test
